//--- verilog/spi_eeprom_command_slave.sv
// Serial command logic of a byte-wide SPI EEPROM slave, array included.
// Assumes the master owns sck and cs_n; sck is idle while cs_n is high.
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_command_slave #(
    parameter int ADDR_W             = eeprom_cmd_pkg::ADDR_W_DEFAULT,
    parameter int WRITE_CYCLE_CYCLES = eeprom_cmd_pkg::WRITE_CYCLE_CLKS
)(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic pause_n,
    input  wire logic write_guard_n,
    output logic      so,
    output logic      so_oe
);

    import eeprom_cmd_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    generate
        if (ADDR_W < ADDR_W_MIN || ADDR_W > ADDR_W_MAX) begin : g_bad_addr_w
            $error("spi_eeprom_command_slave: ADDR_W out of range");
        end
    endgenerate

    function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] level);
        logic hit;
        hit = 1'b0;
        case (level)
            BP_NONE:    hit = 1'b0;
            BP_QUARTER: hit = a[ADDR_W-1] & a[ADDR_W-2];
            BP_HALF:    hit = a[ADDR_W-1];
            default:    hit = 1'b1;
        endcase
        return hit;
    endfunction

    // Core-domain state
    logic [7:0]        mem [DEPTH];
    logic [1:0]        bp;
    logic              wel;
    logic              busy;
    logic              cycle_done;
    logic              cs_s;
    logic              guard_s;
    logic              cs_d;
    logic              guard_fell;
    logic              cs_rise;
    logic              cs_fall;
    logic              prog_go;
    logic              state_go;
    logic              may_write;

    // Link-domain state (sck)
    link_phase_e       phase;
    logic [2:0]        bit_cnt;
    logic [6:0]        shreg;
    logic [2:0]        cmd;
    logic              cmd_valid;
    logic              opc_hi;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        page [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_mask;
    logic              armed;
    logic [1:0]        bp_new;
    logic              out_mode;

    logic [3:0]        st_link;
    logic [7:0]        byte_in;
    logic [7:0]        opc_full;
    logic [8:0]        addr_full;
    logic              byte_done;
    logic              frame_first;
    logic              opc_known;
    logic [7:0]        status_byte;
    logic [7:0]        tx_byte;
    logic [7:0]        mem_rd;

    // Pins into the core clock
    level_sync #(
        .WIDTH (2),
        .INIT  (2'h3)
    ) u_pin_sync (
        .clk (core_clk),
        .rst (rst),
        .d   ({cs_n, write_guard_n}),
        .q   ({cs_s, guard_s})
    );

    // Status levels into the serial clock; they are stable for a whole
    // opcode byte, so eight edges flush the synchroniser before use
    level_sync #(
        .WIDTH (4),
        .INIT  (4'h0)
    ) u_status_sync (
        .clk (sck),
        .rst (1'b0),
        .d   ({busy, wel, bp}),
        .q   (st_link)
    );

    write_cycle_timer #(
        .CYCLES (WRITE_CYCLE_CYCLES)
    ) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (prog_go | state_go),
        .busy     (busy),
        .done     (cycle_done)
    );

    // Link side: shifting and decode

    assign byte_in     = {shreg, si};
    assign opc_full    = byte_in;
    assign addr_full   = {opc_hi, byte_in};
    assign byte_done   = pause_n && (bit_cnt == BIT_LAST);
    assign frame_first = (phase == PH_OPCODE) && (bit_cnt == '0);

    always_comb begin
        opc_known = 1'b0;
        if (opc_full[7:4] == OPC_PREFIX) begin
            case (opc_full[2:0])
                CODE_SET_LATCH, CODE_CLEAR_LATCH, CODE_FETCH_STATE,
                CODE_STORE_STATE, CODE_ARRAY_READ, CODE_ARRAY_WRITE: opc_known = 1'b1;
                default: opc_known = 1'b0;
            endcase
        end
    end

    // Deselect clears the sequencer at once; sck may be still then
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            phase   <= PH_OPCODE;
            bit_cnt <= '0;
        end else if (pause_n && phase != PH_IGNORE) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
                case (phase)
                    PH_OPCODE: begin
                        if (!opc_known) begin
                            phase <= PH_IGNORE;
                        end else if (st_link[3] && opc_full[2:0] != CODE_FETCH_STATE) begin
                            phase <= PH_IGNORE;
                        end else if (opc_full[2:0] == CODE_ARRAY_READ
                                     || opc_full[2:0] == CODE_ARRAY_WRITE) begin
                            phase <= PH_ADDRESS;
                        end else if (opc_full[2:0] == CODE_FETCH_STATE
                                     || opc_full[2:0] == CODE_STORE_STATE) begin
                            phase <= PH_DATA;
                        end else begin
                            phase <= PH_IGNORE;
                        end
                    end
                    PH_ADDRESS: phase <= PH_DATA;
                    default:    phase <= phase;
                endcase
            end
        end
    end

    // Datapath registers keep their value across deselect for the core
    always_ff @(posedge sck) begin
        if (!cs_n && pause_n && phase != PH_IGNORE) begin
            shreg <= byte_in[6:0];
            if (frame_first) begin
                cmd_valid <= 1'b0;
                armed     <= 1'b0;
                page_mask <= '0;
            end
            if (byte_done) begin
                case (phase)
                    PH_OPCODE: begin
                        cmd       <= opc_full[2:0];
                        opc_hi    <= opc_full[OPC_HI_POS];
                        cmd_valid <= opc_known;
                        out_mode  <= opc_full[2:0] == CODE_ARRAY_READ
                                     || opc_full[2:0] == CODE_FETCH_STATE;
                    end
                    PH_ADDRESS: begin
                        addr <= addr_full[ADDR_W-1:0];
                    end
                    default: begin
                        if (cmd == CODE_ARRAY_READ) begin
                            addr <= addr + ADDR_W'(1);
                        end else if (cmd == CODE_ARRAY_WRITE) begin
                            page[addr[PAGE_BITS-1:0]]      <= byte_in;
                            page_mask[addr[PAGE_BITS-1:0]] <= 1'b1;
                            addr <= {addr[ADDR_W-1:PAGE_BITS],
                                     addr[PAGE_BITS-1:0] + PAGE_BITS'(1)};
                        end else if (cmd == CODE_STORE_STATE) begin
                            bp_new <= {byte_in[ST_BP_HI], byte_in[ST_BP_LO]};
                        end
                    end
                endcase
            end
            // Only a deselect right after a full data byte commits a write
            if (phase == PH_DATA) begin
                armed <= byte_done;
            end
        end
    end

    assign mem_rd = mem[addr];

    always_comb begin
        if (st_link[3]) begin
            status_byte = ST_BUSY_ALL;
        end else begin
            status_byte = {ST_UPPER, st_link[1], st_link[0], st_link[2], 1'b0};
        end
    end

    assign tx_byte = (cmd == CODE_FETCH_STATE) ? status_byte : mem_rd;

    // Output changes after falling sck so mode 0 and mode 3 masters both
    // see it settled at their next rising edge
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so_oe <= 1'b0;
            so    <= 1'b0;
        end else if (phase == PH_DATA && out_mode && pause_n) begin
            so_oe <= 1'b1;
            so    <= tx_byte[BIT_LAST - bit_cnt];
        end else begin
            so_oe <= 1'b0;
        end
    end

    // Core side: commit at deselect

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cs_d <= 1'b1;
        end else begin
            cs_d <= cs_s;
        end
    end

    assign cs_rise = cs_s & ~cs_d;
    assign cs_fall = ~cs_s & cs_d;

    // A guard drop inside the frame spoils the whole frame's write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            guard_fell <= 1'b0;
        end else begin
            if (cs_fall) begin
                guard_fell <= 1'b0;
            end
            if (!guard_s && !cs_s) begin
                guard_fell <= 1'b1;
            end
        end
    end

    // Link registers are quiet here: sck stops while deselected
    assign may_write = cs_rise && !busy && wel && guard_s && !guard_fell
                       && cmd_valid && armed;
    assign prog_go   = may_write && cmd == CODE_ARRAY_WRITE;
    assign state_go  = may_write && cmd == CODE_STORE_STATE;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wel <= 1'b0;
        end else if (cycle_done) begin
            wel <= 1'b0;
        end else if (cs_rise && !busy && cmd_valid) begin
            if (cmd == CODE_SET_LATCH && guard_s) begin
                wel <= 1'b1;
            end else if (cmd == CODE_CLEAR_LATCH) begin
                wel <= 1'b0;
            end
        end
    end

    // Nonvolatile in the device; here it restarts at a fixed level
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bp <= BP_RESET;
        end else if (state_go) begin
            bp <= bp_new;
        end
    end

    // One process per array entry; the whole page lands in one cycle and
    // the timer then only reports busy, so a late guard drop is harmless
    generate
        for (genvar j = 0; j < DEPTH; j++) begin : g_entry
            localparam logic [ADDR_W-1:0] ENTRY = ADDR_W'(j);
            always_ff @(posedge core_clk) begin
                if (prog_go
                    && page_mask[ENTRY[PAGE_BITS-1:0]]
                    && addr[ADDR_W-1:PAGE_BITS] == ENTRY[ADDR_W-1:PAGE_BITS]
                    && !is_protected(ENTRY, bp)) begin
                    mem[j] <= page[ENTRY[PAGE_BITS-1:0]];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- shared/eeprom_cmd_pkg.sv
// Constants, codes and phase type for the serial EEPROM command slave.
// Assumes a 10 MHz core clock; the serial clock comes from the master.
package eeprom_cmd_pkg;

    // Array geometry
    localparam int ADDR_W_DEFAULT = 9;
    localparam int ADDR_W_MIN     = 5;
    localparam int ADDR_W_MAX     = 9;
    localparam int PAGE_BITS      = 3;
    localparam int PAGE_BYTES     = 8;

    // Opcode layout: 0000 H ccc, H is the high address bit or a don't-care
    localparam logic [3:0] OPC_PREFIX = 4'h0;
    localparam int         OPC_HI_POS = 3;

    localparam logic [2:0] CODE_SET_LATCH   = 3'h6;
    localparam logic [2:0] CODE_CLEAR_LATCH = 3'h4;
    localparam logic [2:0] CODE_FETCH_STATE = 3'h5;
    localparam logic [2:0] CODE_STORE_STATE = 3'h1;
    localparam logic [2:0] CODE_ARRAY_READ  = 3'h3;
    localparam logic [2:0] CODE_ARRAY_WRITE = 3'h2;

    localparam logic [2:0] BIT_LAST = 3'h7;

    // protection_and_state_word layout
    localparam int         ST_BUSY     = 0;
    localparam int         ST_WEL      = 1;
    localparam int         ST_BP_LO    = 2;
    localparam int         ST_BP_HI    = 3;
    localparam logic [3:0] ST_UPPER    = 4'h0;
    localparam logic [7:0] ST_BUSY_ALL = 8'hFF;

    localparam logic [1:0] BP_NONE    = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF    = 2'h2;
    localparam logic [1:0] BP_ALL     = 2'h3;
    localparam logic [1:0] BP_RESET   = 2'h0;

    // Self-timed write cycle
    localparam int WRITE_CYCLE_MS   = 10;
    localparam int CORE_CLK_HZ      = 10_000_000;
    localparam int WRITE_CYCLE_CLKS = WRITE_CYCLE_MS * (CORE_CLK_HZ / 1000);

    typedef enum logic [1:0] {
        PH_OPCODE  = 2'b00,
        PH_ADDRESS = 2'b01,
        PH_DATA    = 2'b11,
        PH_IGNORE  = 2'b10
    } link_phase_e;

endpackage

//--- verilog/level_sync.sv
// Two-flop synchroniser for quasi-static levels.
// Assumes the destination clock runs while the level matters.
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
)(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("level_sync: WIDTH must be at least 1");
        end
    endgenerate

    // The first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

`default_nettype wire

//--- verilog/write_cycle_timer.sv
// Self-timed program cycle: busy from start until the count expires.
// Assumes start is a single-cycle pulse on the core clock.
`timescale 1ns/1ps
`default_nettype none

module write_cycle_timer #(
    parameter int CYCLES = 100000
)(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    localparam int            CW   = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count;

    generate
        if (CYCLES < 1) begin : g_bad_cycles
            $error("write_cycle_timer: CYCLES must be at least 1");
        end
    endgenerate

    // A start while busy is ignored; the caller never issues one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy  <= 1'b0;
            done  <= 1'b0;
            count <= '0;
        end else begin
            done <= 1'b0;
            if (!busy && start) begin
                busy  <= 1'b1;
                count <= '0;
            end else if (busy) begin
                if (count == LAST) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count + CW'(1);
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- tb/eeprom_cmd_sva.sv
// Port-level checker for the serial EEPROM command slave.
// Assumes sck idles while cs_n is high and pause_n moves only with sck low.
`timescale 1ns/1ps
`default_nettype none

module eeprom_cmd_sva (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic pause_n,
    input wire logic write_guard_n,
    input wire logic so,
    input wire logic so_oe
);
    import eeprom_cmd_pkg::*;

    logic [4:0] bits_seen;
    logic [7:0] opcode;
    logic       op_ok;
    logic       op_read;
    logic       op_fetch;

    // Paused clocks are not counted, as the slave must not count them either
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            bits_seen <= 5'h00;
            opcode    <= 8'h00;
        end else if (pause_n) begin
            if (bits_seen < 5'h08) opcode <= {opcode[6:0], si};
            if (bits_seen < 5'h10) bits_seen <= bits_seen + 5'h01;
        end
    end

    assign op_ok    = opcode[7:4] == OPC_PREFIX && opcode[2:0] != 3'h0 && opcode[2:0] != BIT_LAST;
    assign op_read  = op_ok && opcode[2:0] == CODE_ARRAY_READ;
    assign op_fetch = op_ok && opcode[2:0] == CODE_FETCH_STATE;

    sequence pause_low_s;
        !pause_n;
    endsequence

    sequence running_s;
        pause_n && $past(pause_n);
    endsequence

    deselect_quiet_a: assert property (@(posedge core_clk) disable iff (rst) cs_n |-> !so_oe)
        else $error("so_oe high while deselected");
    pause_quiet_a: assert property (@(negedge sck) disable iff (cs_n) pause_low_s |=> !so_oe)
        else $error("so_oe high while paused");
    opcode_quiet_a: assert property (@(posedge sck) disable iff (cs_n) bits_seen < 5'h08 |-> !so_oe)
        else $error("so_oe high during opcode");
    address_quiet_a: assert property (@(posedge sck) disable iff (cs_n) (op_read && bits_seen < 5'h10) |-> !so_oe)
        else $error("so_oe high during read address");
    bad_opcode_a: assert property (@(posedge sck) disable iff (cs_n) (bits_seen >= 5'h08 && !op_ok) |-> !so_oe)
        else $error("so_oe high after invalid opcode");
    write_quiet_a: assert property (@(posedge sck) disable iff (cs_n) (op_ok && !op_read && !op_fetch) |-> !so_oe)
        else $error("so_oe high in a non-output command");
    status_drive_a: assert property (@(posedge sck) disable iff (cs_n) (op_fetch && bits_seen >= 5'h08) ##0 running_s |-> so_oe)
        else $error("status byte not driven");
    read_stream_a: assert property (@(posedge sck) disable iff (cs_n) (op_read && bits_seen == 5'h10) ##0 running_s |-> so_oe)
        else $error("read data not driven");
endmodule

bind spi_eeprom_command_slave eeprom_cmd_sva u_sva (
    .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n),
    .write_guard_n(write_guard_n), .so(so), .so_oe(so_oe)
);

`default_nettype wire

//--- tb/spi_master_model.sv
// Behavioural mode 0 SPI master for the EEPROM slave's serial pins.
// Assumes the caller spaces frames; sck stands low between frames.
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
    output var logic sck,
    output var logic cs_n,
    output var logic si,
    output var logic pause_n
);
    localparam realtime HALF = 62.5;

    // A short select pulse at start gives every watcher a clean rising edge
    initial begin
        sck     = 1'b0;
        cs_n    = 1'b0;
        si      = 1'b0;
        pause_n = 1'b1;
        #1 cs_n = 1'b1;
    end

    task automatic open_frame();
        cs_n = 1'b0;
        #(HALF);
    endtask

    // A pause of three clocks with random input precedes bit hold_at
    task automatic put_bits(input logic [7:0] tx, input int nbits, input int hold_at);
        for (int i = 7; i > 7 - nbits; i--) begin
            if (i == hold_at) begin
                #(HALF / 2) pause_n = 1'b0;
                repeat (3) begin
                    si = 1'($urandom);
                    #(HALF) sck = 1'b1;
                    #(HALF) sck = 1'b0;
                end
                #(HALF / 2) pause_n = 1'b1;
            end
            si = tx[i];
            #(HALF) sck = 1'b1;
            #(HALF) sck = 1'b0;
        end
    endtask

    task automatic close_frame();
        #(HALF / 2) cs_n = 1'b1;
        // Released line has no pull, so it must not keep the last bit
        si = ~si;
        #400;
    endtask
endmodule

`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the serial EEPROM command slave.
// Assumes the master model and the bound checker beside it.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import eeprom_cmd_pkg::*;

    localparam int WCC = 200;

    logic       core_clk      = 1'b0;
    logic       rst           = 1'b1;
    logic       write_guard_n = 1'b1;
    int         n_fail        = 0;
    int         checked       = 0;
    int         nb            = 0;
    logic [7:0] sh;
    logic [1:0] lv            = 2'h0;
    logic [7:0] exp_q[$];
    logic [7:0] exp_mem[512];
    logic [7:0] bad[4]        = '{8'h00, 8'h07, 8'h13, 8'h85};
    logic [8:0] base[3]       = '{9'h180, 9'h100, 9'h000};
    wire        sck, cs_n, si, pause_n, so, so_oe;

    always #50 core_clk = ~core_clk;

    spi_eeprom_command_slave #(.WRITE_CYCLE_CYCLES(WCC)) dut (
        .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n),
        .write_guard_n(write_guard_n), .so(so), .so_oe(so_oe)
    );
    spi_master_model m (.sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Bytes seen on so are matched in order against the noted expectations
    always @(posedge cs_n) nb = 0;
    always @(posedge sck) begin
        if (so_oe === 1'b1) begin
            sh = {sh[6:0], so};
            nb = nb + 1;
            if (nb == 8) begin
                nb = 0;
                if (exp_q.size() > 0) check(sh, exp_q.pop_front());
                else check(sh, 8'hXX);
            end
        end
    end

    function automatic logic locked(input logic [8:0] a);
        case (lv)
            BP_QUARTER: return a[8:7] == 2'b11;
            BP_HALF:    return a[8];
            BP_ALL:     return 1'b1;
            default:    return 1'b0;
        endcase
    endfunction

    task automatic frame(input logic [7:0] op, input int n);
        m.open_frame();
        m.put_bits(op, 8, -1);
        repeat (n) m.put_bits(8'($urandom), 8, -1);
        m.close_frame();
    endtask

    task automatic fetch(input logic [7:0] exp);
        exp_q.push_back(exp);
        frame({4'h0, 1'($urandom), CODE_FETCH_STATE}, 1);
    endtask

    task automatic guard(input logic v);
        @(posedge core_clk) write_guard_n <= v;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic rd(input logic [8:0] a, input int n);
        for (int i = 0; i < n; i++) exp_q.push_back(exp_mem[9'(a + i)]);
        m.open_frame();
        m.put_bits({4'h0, a[8], CODE_ARRAY_READ}, 8, -1);
        m.put_bits(a[7:0], 8, 3);
        repeat (n) m.put_bits(8'($urandom), 8, -1);
        m.close_frame();
    endtask

    // Modes: 0 good, 1 no latch, 2 guard low, 3 guard dip mid-frame, 4 ragged end
    task automatic wr(input logic [8:0] a, input int n, input int mode);
        logic [8:0] p;
        logic [7:0] d;
        p = a;
        if (mode != 1) frame({4'h0, 1'($urandom), CODE_SET_LATCH}, 0);
        if (mode == 2) guard(1'b0);
        m.open_frame();
        m.put_bits({4'h0, a[8], CODE_ARRAY_WRITE}, 8, -1);
        m.put_bits(a[7:0], 8, -1);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            m.put_bits(d, 8, -1);
            if (mode == 0 && !locked(p)) exp_mem[p] = d;
            p = {p[8:3], p[2:0] + 3'h1};
        end
        if (mode == 3) guard(1'b0);
        if (mode == 3) guard(1'b1);
        if (mode == 4) m.put_bits(8'h00, 3, -1);
        m.close_frame();
        if (mode == 0) begin
            fetch(ST_BUSY_ALL);
            wr(a, 1, 1);
            guard(1'b0);
            repeat (WCC) @(posedge core_clk);
            fetch({4'h0, lv, 2'b00});
        end
        guard(1'b1);
    endtask

    task automatic setlv(input logic [1:0] l);
        frame({4'h0, 1'($urandom), CODE_SET_LATCH}, 0);
        m.open_frame();
        m.put_bits({4'h0, 1'($urandom), CODE_STORE_STATE}, 8, -1);
        m.put_bits({4'h0, l, 2'b00}, 8, -1);
        m.close_frame();
        lv = l;
        repeat (WCC + 10) @(posedge core_clk);
        fetch({4'h0, l, 2'b00});
    endtask

    initial begin
        repeat (90000) @(posedge core_clk);
        n_fail++;
        $display("Timeout at %0t", $time);
        summarize();
    end

    initial begin
        void'($urandom(73));
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        fetch(8'h00);
        frame({4'h0, 1'($urandom), CODE_SET_LATCH}, 0);
        fetch(8'h02);
        foreach (bad[i]) frame(bad[i], 2);
        $display("test commands done");
        wr(9'h0FE, 9, 0);
        rd(9'h0F8, 8);
        for (int k = 1; k < 5; k++) begin
            wr(9'h0F8, 2, k);
            rd(9'h0F8, 2);
        end
        guard(1'b0);
        frame({4'h0, 1'($urandom), CODE_CLEAR_LATCH}, 0);
        guard(1'b1);
        fetch(8'h00);
        $display("test page and refusals done");
        for (int l = 0; l < 4; l++) begin
            setlv(2'(l));
            foreach (base[j]) begin
                wr(base[j] - 9'h001, 1, 0);
                wr(base[j], 1, 0);
                rd(base[j] - 9'h001, 2);
            end
        end
        $display("test protection levels done");
        @(posedge core_clk) rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        lv = 2'h0;
        fetch(8'h00);
        check(8'(exp_q.size()), 8'h00);
        $display("test second reset done");
        summarize();
    end
endmodule

`default_nettype wire
